//--- src/css_channel_sequence_select.v
// css_channel_sequence_select: channel selection, sequencing, busy/eoc and result coding
// assumes synchronous inputs on CLK; the converter core supplies a raw offset-binary code
`timescale 1ns/10ps
`include "css_regs.vh"

module css_channel_sequence_select #(
	parameter CONV_CYCLES = `CSS_CONV_CYCLES
) (
	// clock and reset
	input  wire        CLK,
	input  wire        RESETN,
	input  wire        CE,
	// conversion control
	input  wire        CONVERSION_START_N,
	input  wire        SOURCE_SELECT,
	input  wire        BIPOLAR,
	// hardware pick pins
	input  wire        CHANNEL_PICK_PIN_ONE,
	input  wire        CHANNEL_PICK_PIN_TWO,
	input  wire        CHANNEL_PICK_PIN_THREE,
	input  wire        CHANNEL_PICK_PIN_FOUR,
	// host bus
	input  wire        CS_N,
	input  wire        RD_N,
	input  wire        WR_N,
	input  wire [3:0]  DATA_LINE_IN,
	// converter core result, offset binary from the comparator ladder
	input  wire [13:0] RAW_CODE,
	// status and results
	output reg         BUSY,
	output reg         EOC_N,
	output reg  [1:0]  CHANNEL_INDEX,
	output reg  [13:0] RESULT_CODE,
	output reg         EXT_CLOCK_IN,
	output reg         CLOCK_SOURCE_CHOICE,
	output reg  [3:0]  LATCHED_MASK
);

	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;
	// the counter is twelve bits, so CONV_CYCLES above 4096 would wrap early
	localparam integer CONV_LAST_INT = CONV_CYCLES - 1;
	localparam [11:0]  CONV_LAST     = CONV_LAST_INT[11:0];

	reg        state_ff;
	reg [3:0]  mask_ff;
	reg [3:0]  seq_ff;
	reg [11:0] cnt_ff;
	reg        start_d_ff;
	reg        wr_d_ff;
	reg [3:0]  wdata_ff;

	// next values of the channel register path
	reg        nxt_wr_d;
	reg [3:0]  nxt_wdata;
	reg [3:0]  nxt_mask;

	// next values of the sequencer and its outputs
	reg        nxt_state;
	reg [3:0]  nxt_seq;
	reg [11:0] nxt_cnt;
	reg        nxt_busy;
	reg        nxt_eoc_n;
	reg [1:0]  nxt_index;
	reg [13:0] nxt_result;
	reg [3:0]  nxt_latched;

	wire       write_phase = ~CS_N & ~WR_N & RD_N;
	wire [3:0] pin_pick    = {CHANNEL_PICK_PIN_FOUR, CHANNEL_PICK_PIN_THREE,
	                          CHANNEL_PICK_PIN_TWO, CHANNEL_PICK_PIN_ONE};
	// pins three and four are ignored in software mode; board ties them
	wire [3:0] mux_pick    = SOURCE_SELECT ? mask_ff : pin_pick;
	wire       start_rise  = CONVERSION_START_N & ~start_d_ff;

	// lowest set bit picks the next channel, so order is ascending
	function [1:0] low_ch;
		input [3:0] m;
		begin
			if (m[0]) low_ch = 2'h0;
			else if (m[1]) low_ch = 2'h1;
			else if (m[2]) low_ch = 2'h2;
			else low_ch = 2'h3;
		end
	endfunction

	// offset-binary core code to output coding; top bit flip gives two's complement
	function [13:0] code_of;
		input [13:0] raw;
		input        bip;
		begin
			code_of = bip ? {~raw[13], raw[12:0]} : raw;
		end
	endfunction

	// one-hot bit of a channel index
	function [3:0] ch_bit;
		input [1:0] idx;
		begin
			ch_bit = 4'h1 << idx;
		end
	endfunction

	// write strobe rose after a sampled write phase
	wire       write_done = wr_d_ff & WR_N;
	wire       conv_end   = (cnt_ff == CONV_LAST);
	// channels still waiting once the current one has finished
	wire [3:0] seq_left   = seq_ff & ~ch_bit(CHANNEL_INDEX);

	// register write: data held from the write phase, loaded when the strobe rises
	always @* begin
		nxt_wr_d  = write_phase;
		nxt_wdata = wdata_ff;
		nxt_mask  = mask_ff;
		if (write_phase)
			nxt_wdata = DATA_LINE_IN;
		// a phase that ends by chip select alone loads nothing
		if (write_done)
			nxt_mask = wdata_ff;
	end

	// sequencer: latches the selection at start, then walks it lowest channel first
	always @* begin
		nxt_state   = state_ff;
		nxt_seq     = seq_ff;
		nxt_cnt     = cnt_ff;
		nxt_busy    = BUSY;
		nxt_eoc_n   = 1'b1;
		nxt_index   = CHANNEL_INDEX;
		nxt_result  = RESULT_CODE;
		nxt_latched = LATCHED_MASK;
		case (state_ff)
			ST_IDLE: begin
				// an empty selection starts nothing, so busy stays low
				if (start_rise && mux_pick != 4'h0) begin
					nxt_seq     = mux_pick;
					nxt_latched = mux_pick;
					nxt_index   = low_ch(mux_pick);
					nxt_cnt     = 12'h000;
					nxt_busy    = 1'b1;
					nxt_state   = ST_CONV;
				end
			end
			ST_CONV: begin
				// starts are ignored here, so the latched selection stays put
				if (conv_end) begin
					nxt_cnt    = 12'h000;
					nxt_eoc_n  = 1'b0;
					nxt_result = code_of(RAW_CODE, BIPOLAR);
					nxt_seq    = seq_left;
					if (seq_left == 4'h0) begin
						nxt_busy  = 1'b0;
						nxt_state = ST_IDLE;
					end else begin
						nxt_index = low_ch(seq_left);
					end
				end else begin
					nxt_cnt = cnt_ff + 12'h001;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// channel register; reset leaves no channel chosen
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mask_ff  <= `CSS_MASK_RESET;
			wr_d_ff  <= 1'b0;
			wdata_ff <= 4'h0;
		end else if (CE) begin
			wr_d_ff  <= nxt_wr_d;
			wdata_ff <= nxt_wdata;
			mask_ff  <= nxt_mask;
		end
	end

	// all state and outputs freeze while CE is low
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff            <= ST_IDLE;
			seq_ff              <= 4'h0;
			cnt_ff              <= 12'h000;
			// idle level of the start pin is high, so no false edge follows reset
			start_d_ff          <= 1'b1;
			BUSY                <= 1'b0;
			EOC_N               <= 1'b1;
			CHANNEL_INDEX       <= 2'h0;
			RESULT_CODE         <= `CSS_ZERO_CODE;
			EXT_CLOCK_IN        <= 1'b0;
			CLOCK_SOURCE_CHOICE <= 1'b0;
			LATCHED_MASK        <= 4'h0;
		end else if (CE) begin
			start_d_ff          <= CONVERSION_START_N;
			state_ff            <= nxt_state;
			seq_ff              <= nxt_seq;
			cnt_ff              <= nxt_cnt;
			BUSY                <= nxt_busy;
			EOC_N               <= nxt_eoc_n;
			CHANNEL_INDEX       <= nxt_index;
			RESULT_CODE         <= nxt_result;
			LATCHED_MASK        <= nxt_latched;
			// dual-function pins only mean clock controls in software mode
			EXT_CLOCK_IN        <= SOURCE_SELECT & CHANNEL_PICK_PIN_ONE;
			CLOCK_SOURCE_CHOICE <= SOURCE_SELECT & CHANNEL_PICK_PIN_TWO;
		end
	end

endmodule // css_channel_sequence_select

//--- include/css_regs.vh
// css_regs.vh: constants for the channel sequence select block
// assumes a single 125 MHz clock; included by bare name
`ifndef CSS_REGS_VH
`define CSS_REGS_VH
`define CSS_NUM_CH        4
`define CSS_MASK_RESET    4'h0
`define CSS_CODE_WIDTH    14
`define CSS_CONV_TIME_NS  2400
`define CSS_CLK_PERIOD_NS 8
`define CSS_CONV_CYCLES   (`CSS_CONV_TIME_NS / `CSS_CLK_PERIOD_NS)
`define CSS_BIP_NEG_FS    14'h2000
`define CSS_BIP_POS_FS    14'h1FFF
`define CSS_UNI_TOP       14'h3FFF
`define CSS_ZERO_CODE     14'h0000
`endif

//--- verification/css_chk_assertions.sv
// css_chk: port-level checks of sequencing, latching and result coding
// assumes CE held high and RAW_CODE, BIPOLAR steady within a sequence
`timescale 1ns/10ps
module css_chk (
	// watched ports
	input wire CLK, RESETN, CONVERSION_START_N, BUSY, EOC_N, BIPOLAR, SOURCE_SELECT,
	input wire CHANNEL_PICK_PIN_ONE, EXT_CLOCK_IN,
	input wire [1:0] CHANNEL_INDEX,
	input wire [3:0] LATCHED_MASK,
	input wire [13:0] RAW_CODE, RESULT_CODE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	busy_on_start_a: assert property ($rose(BUSY) |-> $past(CONVERSION_START_N)
		&& !$past(CONVERSION_START_N, 2)) else $error("busy rise");
	eoc_pulse_a: assert property (!EOC_N |=> EOC_N) else $error("eoc");
	busy_last_a: assert property ($fell(BUSY) |-> !EOC_N) else $error("busy fall");
	eoc_in_seq_a: assert property (!EOC_N |-> $past(BUSY)) else $error("eoc idle");
	mask_hold_a: assert property (BUSY && $past(BUSY) |-> $stable(LATCHED_MASK))
		else $error("mask moved");
	index_picked_a: assert property (BUSY |-> LATCHED_MASK[CHANNEL_INDEX])
		else $error("index");
	result_code_a: assert property (!EOC_N |-> RESULT_CODE ==
		($past(RAW_CODE) ^ {BIPOLAR, 13'h0000})) else $error("code");
	ext_clock_a: assert property ($past(RESETN) |-> EXT_CLOCK_IN ==
		($past(SOURCE_SELECT) & $past(CHANNEL_PICK_PIN_ONE))) else $error("clock in");
endmodule // css_chk
bind css_channel_sequence_select css_chk css_chk_inst (
	.CLK(CLK), .RESETN(RESETN), .CONVERSION_START_N(CONVERSION_START_N),
	.BUSY(BUSY), .EOC_N(EOC_N), .BIPOLAR(BIPOLAR), .SOURCE_SELECT(SOURCE_SELECT),
	.CHANNEL_PICK_PIN_ONE(CHANNEL_PICK_PIN_ONE), .EXT_CLOCK_IN(EXT_CLOCK_IN),
	.CHANNEL_INDEX(CHANNEL_INDEX), .LATCHED_MASK(LATCHED_MASK),
	.RAW_CODE(RAW_CODE), .RESULT_CODE(RESULT_CODE)
);

//--- verification/css_host_model.sv
// css_host_model: host on the parallel bus, write cycles only
// assumes one caller at a time
`timescale 1ns/10ps
module css_host_model (
	// host bus
	input wire CLK,
	output reg CS_N = 1, RD_N = 1, WR_N = 1,
	output reg [3:0] DATA_LINE_IN = 4'h0
);
	// rd low makes the cycle one the device must refuse
	task wr(input [3:0] d, input rd);
		begin
			@(posedge CLK) #1;
			{CS_N, RD_N, WR_N, DATA_LINE_IN} = {1'b0, rd, 1'b0, d};
			@(posedge CLK) #1;
			{CS_N, RD_N, WR_N} = 3'h7;
			@(posedge CLK) #1;
			DATA_LINE_IN = ~d; // released lines must not look like the last value
		end
	endtask
endmodule // css_host_model

//--- verification/css_channel_sequence_select_tb_top.sv
// css_channel_sequence_select_tb_top: directed sequence, latch and coding tests
// assumes CONV_CYCLES shortened to 4
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module css_channel_sequence_select_tb_top;
	reg CLK = 0, RESETN = 0, CE = 1, CONVERSION_START_N = 0, SOURCE_SELECT = 0, BIPOLAR = 0;
	reg [3:0] pins = 4'h0;
	reg [13:0] RAW_CODE = 14'h0000;
	reg [7:0] got;
	reg [1:0] prev_idx = 2'h0;
	wire CS_N, RD_N, WR_N, BUSY, EOC_N, EXT_CLOCK_IN, CLOCK_SOURCE_CHOICE;
	wire [3:0] DATA_LINE_IN, LATCHED_MASK;
	wire [1:0] CHANNEL_INDEX;
	wire [13:0] RESULT_CODE;
	wire CHANNEL_PICK_PIN_ONE = pins[0], CHANNEL_PICK_PIN_TWO = pins[1];
	wire CHANNEL_PICK_PIN_THREE = pins[2], CHANNEL_PICK_PIN_FOUR = pins[3];
	integer fail_count = 0, num_checks = 0, cyc = 0;
	css_channel_sequence_select #(.CONV_CYCLES(4)) css_channel_sequence_select_inst (
		.CLK(CLK), .RESETN(RESETN), .CE(CE), .CONVERSION_START_N(CONVERSION_START_N),
		.SOURCE_SELECT(SOURCE_SELECT), .BIPOLAR(BIPOLAR),
		.CHANNEL_PICK_PIN_ONE(CHANNEL_PICK_PIN_ONE), .CHANNEL_PICK_PIN_TWO(CHANNEL_PICK_PIN_TWO),
		.CHANNEL_PICK_PIN_THREE(CHANNEL_PICK_PIN_THREE),
		.CHANNEL_PICK_PIN_FOUR(CHANNEL_PICK_PIN_FOUR),
		.CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .DATA_LINE_IN(DATA_LINE_IN), .RAW_CODE(RAW_CODE),
		.BUSY(BUSY), .EOC_N(EOC_N), .CHANNEL_INDEX(CHANNEL_INDEX), .RESULT_CODE(RESULT_CODE),
		.EXT_CLOCK_IN(EXT_CLOCK_IN), .CLOCK_SOURCE_CHOICE(CLOCK_SOURCE_CHOICE),
		.LATCHED_MASK(LATCHED_MASK)
	);
	css_host_model css_host_model_inst (
		.CLK(CLK), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .DATA_LINE_IN(DATA_LINE_IN)
	);
	initial forever #4 CLK = ~CLK;
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	always @(posedge CLK) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			wrap_up;
		end
	end
	// in pin mode pins flip once latched, so a leak of the live selection shows up
	task seq(input [3:0] p, input [3:0] m, input [7:0] ord, input [13:0] r, input [13:0] e);
		begin
			{pins, RAW_CODE, got} = {p, r, 8'hFF};
			@(posedge CLK) #1 CONVERSION_START_N = 1;
			// software mode keeps pins three and four tied at one level
			@(posedge CLK) #1 pins = SOURCE_SELECT ? p : ~p;
			repeat (30) begin
				if (EOC_N === 1'b0) begin
					// the index moves on with the end pulse; the channel that ended is last cycle's
					got = {got[5:0], prev_idx};
					`CHK("result", e, RESULT_CODE)
				end
				prev_idx = CHANNEL_INDEX;
				@(posedge CLK) #1;
			end
			`CHK("mask", m, LATCHED_MASK)
			`CHK("order", ord, got)
			`CHK("busy", 1'b0, BUSY)
			`CHK("clock in", SOURCE_SELECT & pins[0], EXT_CLOCK_IN)
			`CHK("clock choice", SOURCE_SELECT & pins[1], CLOCK_SOURCE_CHOICE)
			CONVERSION_START_N = 0;
			$display("sequence done, mask %h", m);
		end
	endtask
	initial begin
		repeat (6) @(posedge CLK);
		#1 RESETN = 1;
		seq(4'hD, 4'hD, 8'hCB, 14'h0000, 14'h0000);
		BIPOLAR = 1;
		seq(4'h1, 4'h1, 8'hFC, 14'h0000, 14'h2000);
		seq(4'hF, 4'hF, 8'h1B, 14'h3FFF, 14'h1FFF);
		{SOURCE_SELECT, BIPOLAR} = 2'h2;
		css_host_model_inst.wr(4'h6, 1'b1);
		seq(4'h3, 4'h6, 8'hF6, 14'h3FFF, 14'h3FFF);
		css_host_model_inst.wr(4'h1, 1'b0);
		seq(4'h0, 4'h6, 8'hF6, 14'h1234, 14'h1234);
		wrap_up;
	end
endmodule // css_channel_sequence_select_tb_top
